//--- core/adc_system_control_options.sv
// System control register, monitor side effects and conversion result framing.
`timescale 1ns/1ps
module adc_system_control_options (
    input wire logic clock,
    input wire logic rst,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic [2:0] gainConfig,
    output logic [2:0] gainEffective,
    output logic muxOpen,
    output logic [4:0] calSampleCount,
    output logic timeoutEnable,
    output logic [1:0] burnoutLevel,
    input wire logic readStart,
    input wire logic [23:0] convData,
    input wire logic [7:0] convStatus,
    output logic [7:0] outByte,
    output logic outValid,
    output logic outLast,
    output logic busy
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] sysReg;
        logic [7:0] rdData;
        logic rdValid;
        logic [2:0] gain;
        logic muxOpen;
        logic [4:0] calCount;
        logic timeoutEn;
        logic [1:0] burnout;
        sysctl_pkg::frame_state_type frame;
        logic withStatus;
        logic withCrc;
        logic [7:0] statusByte;
        logic [23:0] data;
        logic [7:0] outByte;
        logic outValid;
        logic outLast;
        logic busy;
    } ctl_state_type;

    localparam ctl_state_type RESET_STATE = '{
        sysReg: sysctl_pkg::SYSCTL_RESET,
        rdData: 8'h00,
        rdValid: 1'b0,
        gain: 3'h0,
        muxOpen: 1'b0,
        calCount: sysctl_pkg::CAL_COUNT_2,
        timeoutEn: 1'b0,
        burnout: sysctl_pkg::BURNOUT_NONE,
        frame: sysctl_pkg::FR_IDLE,
        withStatus: 1'b0,
        withCrc: 1'b0,
        statusByte: 8'h00,
        data: 24'h000000,
        outByte: 8'h00,
        outValid: 1'b0,
        outLast: 1'b0,
        busy: 1'b0
    };

    ctl_state_type state_q;
    ctl_state_type state_d;
    crc_if crcLink ();

    crc_accumulator crcUnit (
        .clock(clock),
        .rst(rst),
        .link(crcLink)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic [2:0] mon;
        mon = 3'h0;
        state_d = state_q;
        crcLink.clear = 1'b0;
        crcLink.feed = 1'b0;
        crcLink.data = 8'h00;

        if (regWrite && regAddr == sysctl_pkg::SYSCTL_ADDR)
        begin
            state_d.sysReg = regWrData;
        end
        state_d.rdValid = regRead;
        if (regRead)
        begin
            state_d.rdData = (regAddr == sysctl_pkg::SYSCTL_ADDR) ? state_q.sysReg
                : sysctl_pkg::UNMAPPED_READ;
        end

        // Side effects follow the value being stored, so they line up with the register.
        mon = state_d.sysReg[sysctl_pkg::MON_HI:sysctl_pkg::MON_LO];
        unique case (state_d.sysReg[sysctl_pkg::CAL_HI:sysctl_pkg::CAL_LO])
            2'h0: state_d.calCount = sysctl_pkg::CAL_COUNT_0;
            2'h1: state_d.calCount = sysctl_pkg::CAL_COUNT_1;
            2'h2: state_d.calCount = sysctl_pkg::CAL_COUNT_2;
            2'h3: state_d.calCount = sysctl_pkg::CAL_COUNT_3;
        endcase
        state_d.timeoutEn = state_d.sysReg[sysctl_pkg::TIMEOUT_BIT];
        state_d.muxOpen = (mon == sysctl_pkg::MON_MID_SUPPLY) || (mon == sysctl_pkg::MON_TEMP)
            || (mon == sysctl_pkg::MON_ANALOG_DIV4) || (mon == sysctl_pkg::MON_DIGITAL_DIV4);
        // The divide-by-4 supply monitors force unity gain; mid-supply and the temperature sensor keep the host's gain.
        state_d.gain = (mon == sysctl_pkg::MON_ANALOG_DIV4 || mon == sysctl_pkg::MON_DIGITAL_DIV4)
            ? sysctl_pkg::GAIN_UNITY : gainConfig;
        unique case (mon)
            sysctl_pkg::MON_BURNOUT_LOW: state_d.burnout = 2'h1;
            sysctl_pkg::MON_BURNOUT_MID: state_d.burnout = 2'h2;
            sysctl_pkg::MON_BURNOUT_HIGH: state_d.burnout = 2'h3;
            default: state_d.burnout = sysctl_pkg::BURNOUT_NONE;
        endcase

        // Framing options are latched at the start so a write mid-frame cannot tear it.
        state_d.outValid = 1'b0;
        state_d.outLast = 1'b0;
        unique case (state_q.frame)
            sysctl_pkg::FR_IDLE:
            begin
                if (readStart)
                begin
                    crcLink.clear = 1'b1;
                    state_d.withStatus = state_q.sysReg[sysctl_pkg::STATUS_BIT];
                    state_d.withCrc = state_q.sysReg[sysctl_pkg::CRC_BIT];
                    state_d.statusByte = convStatus;
                    state_d.data = convData;
                    state_d.frame = state_q.sysReg[sysctl_pkg::STATUS_BIT]
                        ? sysctl_pkg::FR_STATUS : sysctl_pkg::FR_BYTE2;
                end
            end
            sysctl_pkg::FR_STATUS:
            begin
                crcLink.feed = 1'b1;
                crcLink.data = state_q.statusByte;
                state_d.outByte = state_q.statusByte;
                state_d.outValid = 1'b1;
                state_d.frame = sysctl_pkg::FR_BYTE2;
            end
            sysctl_pkg::FR_BYTE2:
            begin
                crcLink.feed = 1'b1;
                crcLink.data = state_q.data[23:16];
                state_d.outByte = state_q.data[23:16];
                state_d.outValid = 1'b1;
                state_d.frame = sysctl_pkg::FR_BYTE1;
            end
            sysctl_pkg::FR_BYTE1:
            begin
                crcLink.feed = 1'b1;
                crcLink.data = state_q.data[15:8];
                state_d.outByte = state_q.data[15:8];
                state_d.outValid = 1'b1;
                state_d.frame = sysctl_pkg::FR_BYTE0;
            end
            sysctl_pkg::FR_BYTE0:
            begin
                crcLink.feed = 1'b1;
                crcLink.data = state_q.data[7:0];
                state_d.outByte = state_q.data[7:0];
                state_d.outValid = 1'b1;
                // CRC byte only when enabled, otherwise the frame ends here.
                state_d.outLast = !state_q.withCrc;
                state_d.frame = state_q.withCrc ? sysctl_pkg::FR_CRC : sysctl_pkg::FR_IDLE;
            end
            sysctl_pkg::FR_CRC:
            begin
                // The accumulator already holds the CRC of every byte sent.
                state_d.outByte = crcLink.crc;
                state_d.outValid = 1'b1;
                state_d.outLast = 1'b1;
                state_d.frame = sysctl_pkg::FR_IDLE;
            end
            default:
            begin
                state_d.frame = sysctl_pkg::FR_IDLE;
            end
        endcase
        // Busy has a flop of its own so the pin does not carry decode glitches.
        state_d.busy = (state_d.frame != sysctl_pkg::FR_IDLE);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q <= RESET_STATE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign regRdData = state_q.rdData;
    assign regRdValid = state_q.rdValid;
    assign gainEffective = state_q.gain;
    assign muxOpen = state_q.muxOpen;
    assign calSampleCount = state_q.calCount;
    assign timeoutEnable = state_q.timeoutEn;
    assign burnoutLevel = state_q.burnout;
    assign outByte = state_q.outByte;
    assign outValid = state_q.outValid;
    assign outLast = state_q.outLast;
    assign busy = state_q.busy;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic [2:0] monNow;
    logic [7:0] expectCrc;
    logic startIdle;
    assign monNow = state_q.sysReg[sysctl_pkg::MON_HI:sysctl_pkg::MON_LO];
    assign startIdle = readStart && !busy;
    assign expectCrc = sysctl_pkg::crc8_step(sysctl_pkg::crc8_step(sysctl_pkg::crc8_step(
        state_q.withStatus ? sysctl_pkg::crc8_step(sysctl_pkg::CRC_INIT, state_q.statusByte)
        : sysctl_pkg::CRC_INIT, state_q.data[23:16]), state_q.data[15:8]), state_q.data[7:0]);

    a_cal_count_map: assert property (calSampleCount ==
        (5'h01 << ({1'b0, state_q.sysReg[4:3]} + ((state_q.sysReg[4:3] != 2'h0) ? 3'h1 : 3'h0))))
        else $error("calibration count does not match field");
    a_timeout_follow: assert property (regWrite && regAddr == 5'h09
        |=> timeoutEnable == $past(regWrData[2]))
        else $error("timeout enable not taken from write");
    a_crc_frame_len: assert property (startIdle && state_q.sysReg[1:0] == 2'h3
        |=> !outValid ##1 outValid[*5] ##1 !outValid)
        else $error("status plus CRC frame not five bytes");
    a_crc_value: assert property (outValid && outLast && state_q.withCrc
        |-> outByte == $past(expectCrc))
        else $error("CRC byte wrong");
    a_status_first: assert property (startIdle && state_q.sysReg[0]
        |=> ##1 outByte == $past(convStatus, 2))
        else $error("status byte not sent first");
    a_mux_open: assert property (muxOpen == (monNow inside {3'h1, 3'h2, 3'h3, 3'h4}))
        else $error("multiplexer state wrong for monitor");
    a_gain_forced: assert property (monNow inside {3'h3, 3'h4} |-> gainEffective == 3'h0)
        else $error("gain not forced to one");
    a_monitor_decode: assert property ((burnoutLevel != 2'h0) == (monNow >= 3'h5))
        else $error("burn-out decode wrong");
    a_reg_readback: assert property ((regWrite && regAddr == 5'h09)
        ##1 (regRead && regAddr == 5'h09)
        |=> regRdValid && regRdData == $past(regWrData, 2))
        else $error("readback differs from write");
    a_plain_frame: assert property (startIdle && state_q.sysReg[1:0] == 2'h0
        |=> !outValid ##1 outValid[*3] ##1 !outValid)
        else $error("plain frame not three bytes");

    c_full_frame: cover property (startIdle && state_q.sysReg[1:0] == 2'h3);
    c_plain_frame: cover property (startIdle && state_q.sysReg[1:0] == 2'h0);
    c_supply_monitor: cover property (monNow == 3'h4 && gainConfig != 3'h0);
    c_temp_monitor: cover property (monNow == 3'h2 && muxOpen);
endmodule

//--- include/sysctl_pkg.sv
// Constants, field layout and the CRC step shared by the system control block.
package sysctl_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_WIDTH = 5;
    localparam logic [4:0] SYSCTL_ADDR = 5'h09;
    localparam logic [7:0] SYSCTL_RESET = 8'h10;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int MON_HI = 7;
    localparam int MON_LO = 5;
    localparam int CAL_HI = 4;
    localparam int CAL_LO = 3;
    localparam int TIMEOUT_BIT = 2;
    localparam int CRC_BIT = 1;
    localparam int STATUS_BIT = 0;

    // ****************************************************************
    // System monitor selections
    // ****************************************************************
    localparam logic [2:0] MON_OFF = 3'h0;
    localparam logic [2:0] MON_MID_SUPPLY = 3'h1;
    localparam logic [2:0] MON_TEMP = 3'h2;
    localparam logic [2:0] MON_ANALOG_DIV4 = 3'h3;
    localparam logic [2:0] MON_DIGITAL_DIV4 = 3'h4;
    localparam logic [2:0] MON_BURNOUT_LOW = 3'h5;
    localparam logic [2:0] MON_BURNOUT_MID = 3'h6;
    localparam logic [2:0] MON_BURNOUT_HIGH = 3'h7;

    // ****************************************************************
    // Calibration averaging counts, gain and burn-out codes
    // ****************************************************************
    localparam logic [4:0] CAL_COUNT_0 = 5'h01;
    localparam logic [4:0] CAL_COUNT_1 = 5'h04;
    localparam logic [4:0] CAL_COUNT_2 = 5'h08;
    localparam logic [4:0] CAL_COUNT_3 = 5'h10;
    localparam logic [2:0] GAIN_UNITY = 3'h0;
    localparam logic [1:0] BURNOUT_NONE = 2'h0;

    // ****************************************************************
    // Result framing and CRC
    // ****************************************************************
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    typedef enum logic [2:0] {
        FR_IDLE,
        FR_STATUS,
        FR_BYTE2,
        FR_BYTE1,
        FR_BYTE0,
        FR_CRC
    } frame_state_type;

    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++)
        begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

endpackage

//--- include/crc_if.sv
// Link between the result framer and its CRC accumulator.
`timescale 1ns/1ps
interface crc_if;
    logic clear;
    logic feed;
    logic [7:0] data;
    logic [7:0] crc;

    modport framer (output clear, output feed, output data, input crc);
    modport engine (input clear, input feed, input data, output crc);
endinterface

//--- core/crc_accumulator.sv
// Running CRC-8 over the bytes of one framed conversion result.
`timescale 1ns/1ps
module crc_accumulator (
    input wire logic clock,
    input wire logic rst,
    crc_if.engine link
);
    typedef struct packed {
        logic [7:0] crc;
    } crc_state_type;

    crc_state_type state_q;
    crc_state_type state_d;

    always_comb
    begin
        state_d = state_q;
        if (link.clear)
        begin
            state_d.crc = sysctl_pkg::CRC_INIT;
        end
        else if (link.feed)
        begin
            state_d.crc = sysctl_pkg::crc8_step(state_q.crc, link.data);
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '{crc: sysctl_pkg::CRC_INIT};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign link.crc = state_q.crc;
endmodule

//--- verification/host_receiver.sv
// Host-side model that collects framed conversion results and checks their CRC.
`timescale 1ns/1ps
module host_receiver (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] outByte,
    input wire logic outValid,
    input wire logic outLast,
    output logic [7:0] rxBytes [0:4],
    output logic [2:0] rxCount,
    output logic [7:0] rxResidue,
    output logic [7:0] frameCount
);
    logic inFrame;
    logic [2:0] idx;

    // Written apart from the design's own step so that a shared slip cannot hide.
    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++)
        begin
            r = {r[6:0], 1'h0} ^ (r[7] ? 8'h07 : 8'h00);
        end
        return r;
    endfunction

    always_comb idx = inFrame ? rxCount : 3'h0;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            inFrame <= 1'h0;
            rxCount <= 3'h0;
            rxResidue <= 8'h00;
            frameCount <= 8'h00;
            for (int i = 0; i < 5; i++)
                rxBytes[i] <= 8'h00;
        end
        else if (outValid)
        begin
            rxBytes[idx] <= outByte;
            rxCount <= idx + 3'h1;
            rxResidue <= crcStep(inFrame ? rxResidue : 8'h00, outByte);
            inFrame <= !outLast;
            if (outLast)
                frameCount <= frameCount + 8'h01;
        end
    end
endmodule

//--- verification/tb_top.sv
// Self-checking testbench for the system control register and result framing.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        numChecks++; \
        if ((got) !== (exp)) \
        begin \
            nMismatch++; \
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module tb_top;
    localparam logic [4:0] ADDR = sysctl_pkg::SYSCTL_ADDR;
    localparam int WATCHDOG_CYCLES = 5000;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic [2:0] gainConfig = 3'h0;
    logic readStart = 1'h0;
    logic [23:0] convData = 24'h000000;
    logic [7:0] convStatus = 8'h00;
    logic [7:0] regRdData, outByte, rxResidue, frameCount;
    logic [7:0] rxBytes [0:4];
    logic [4:0] calSampleCount;
    logic [2:0] gainEffective, rxCount;
    logic [1:0] burnoutLevel;
    logic regRdValid, muxOpen, timeoutEnable, outValid, outLast, busy;
    int nMismatch = 0;
    int numChecks = 0;

    always #10 clock = !clock;

    adc_system_control_options adc_system_control_options_i (
        .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .regRdValid(regRdValid), .gainConfig(gainConfig), .gainEffective(gainEffective),
        .muxOpen(muxOpen), .calSampleCount(calSampleCount), .timeoutEnable(timeoutEnable),
        .burnoutLevel(burnoutLevel), .readStart(readStart), .convData(convData),
        .convStatus(convStatus), .outByte(outByte), .outValid(outValid),
        .outLast(outLast), .busy(busy)
    );

    host_receiver host_receiver_i (
        .clock(clock), .rst(rst), .outByte(outByte), .outValid(outValid),
        .outLast(outLast), .rxBytes(rxBytes), .rxCount(rxCount),
        .rxResidue(rxResidue), .frameCount(frameCount)
    );

    // ****************************************************************
    // Register bus cycles
    // ****************************************************************
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrData = d;
        regWrite = 1'h1;
        @(negedge clock);
        regWrite = 1'h0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regRead = 1'h1;
        @(negedge clock);
        regRead = 1'h0;
        for (int i = 0; i < 4 && regRdValid !== 1'h1; i++)
            @(negedge clock);
        `CHK(regRdValid, 1'h1)
        d = regRdData;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic reset_values();
        logic [7:0] v;
        rd(ADDR, v);
        `CHK(v, 8'h10)
        `CHK(calSampleCount, 5'h08)
        `CHK(timeoutEnable, 1'h0)
        `CHK({muxOpen, burnoutLevel, gainEffective, busy}, 7'h00)
    endtask

    task automatic cal_and_timeout();
        logic [4:0] counts [0:3] = '{5'h01, 5'h04, 5'h08, 5'h10};
        logic [7:0] v;
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR, {3'h0, k[1:0], k[0], 2'h0});
            `CHK(calSampleCount, counts[k])
            `CHK(timeoutEnable, k[0])
            rd(ADDR, v);
            `CHK(v, {3'h0, k[1:0], k[0], 2'h0})
        end
    endtask

    task automatic unmapped();
        logic [7:0] v;
        wr(ADDR, 8'h2c);
        wr(5'h0a, 8'hff);
        rd(5'h0a, v);
        `CHK(v, 8'h00)
        rd(ADDR, v);
        `CHK(v, 8'h2c)
    endtask

    // A read in the write cycle sees the old value, the next cycle the new one.
    task automatic back_to_back();
        @(negedge clock);
        regAddr = ADDR;
        regWrData = 8'h75;
        regWrite = 1'h1;
        regRead = 1'h1;
        @(negedge clock);
        regWrite = 1'h0;
        `CHK(regRdValid, 1'h1)
        `CHK(regRdData, 8'h2c)
        @(negedge clock);
        regRead = 1'h0;
        `CHK(regRdValid, 1'h1)
        `CHK(regRdData, 8'h75)
        @(negedge clock);
        `CHK(regRdValid, 1'h0)
    endtask

    task automatic monitors();
        logic [2:0] m;
        for (int k = 0; k < 8; k++)
        begin
            m = k[2:0];
            gainConfig = (m == sysctl_pkg::MON_TEMP) ? 3'h2 : 3'h5;
            wr(ADDR, {m, 5'h10});
            @(negedge clock);
            `CHK(muxOpen, (m >= 3'h1 && m <= 3'h4))
            `CHK(gainEffective, (m == 3'h3 || m == 3'h4) ? 3'h0 : gainConfig)
            `CHK(burnoutLevel, (m >= 3'h5) ? m - 3'h4 : 3'h0)
        end
    endtask

    task automatic frame(input logic [1:0] opt, input logic [23:0] d, input logic [7:0] st);
        logic [7:0] e [0:4];
        logic [7:0] f0;
        int n;
        n = 0;
        if (opt[0])
        begin
            e[0] = st;
            n = 1;
        end
        e[n] = d[23:16];
        e[n + 1] = d[15:8];
        e[n + 2] = d[7:0];
        n = n + 3;
        wr(ADDR, {6'h02, opt});
        f0 = frameCount;
        @(negedge clock);
        convData = d;
        convStatus = st;
        readStart = 1'h1;
        @(negedge clock);
        readStart = 1'h0;
        // A second start while busy must be ignored.
        @(negedge clock);
        readStart = 1'h1;
        @(negedge clock);
        readStart = 1'h0;
        for (int i = 0; i < 20 && frameCount === f0; i++)
            @(negedge clock);
        repeat (8) @(negedge clock);
        `CHK(frameCount, f0 + 8'h01)
        `CHK(rxCount, n + opt[1])
        for (int i = 0; i < n; i++)
            `CHK(rxBytes[i], e[i])
        if (opt[1])
            `CHK(rxResidue, 8'h00)
        `CHK(busy, 1'h0)
    endtask

    // ****************************************************************
    // Closing and sequence
    // ****************************************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(negedge clock);
        rst = 1'h0;
        reset_values();
        cal_and_timeout();
        unmapped();
        back_to_back();
        monitors();
        frame(2'h0, 24'h81c3a5, 8'h5a);
        frame(2'h1, 24'h00ff01, 8'hc4);
        frame(2'h2, 24'hfedcba, 8'h11);
        frame(2'h3, 24'h123456, 8'h80);
        frame(2'h3, 24'hffffff, 8'hff);
        complete_run();
    end

    // Generous margin over the fewer than two hundred cycles the sequence needs.
    initial
    begin
        repeat (WATCHDOG_CYCLES) @(posedge clock);
        nMismatch++;
        complete_run();
    end
endmodule
